// ---- core/dall_link.sv ----
`timescale 1ns/1ps
`default_nettype none
module dall_link (
    input wire logic clk,
    input wire logic sys_rst,
    input wire dall_pkg::dall_mode_t link_mode,
    input wire logic [7:0] byte_rx_data,
    input wire logic byte_rx_valid,
    output logic byte_rx_ready,
    output logic [7:0] byte_tx_data,
    output logic byte_tx_valid,
    input wire logic byte_tx_ready,
    input wire logic [31:0] mbx_rx_word,
    input wire logic mbx_rx_valid,
    output logic mbx_rx_ready,
    output logic [31:0] mbx_tx_word,
    output logic mbx_tx_valid,
    input wire logic mbx_tx_ready,
    input wire logic [dall_pkg::WIN_AW-1:0] win_host_addr,
    input wire logic win_host_we,
    input wire logic [31:0] win_host_wdata,
    output logic [31:0] win_host_rdata,
    output logic [31:0] req_word,
    output logic req_valid,
    output logic req_last,
    input wire logic req_ready,
    input wire logic [31:0] rsp_word,
    input wire logic rsp_valid,
    output logic rsp_ready
);
    import dall_pkg::*;

    dall_win_if win_bus ();

    dall_window u_window (
        .clk(clk),
        .sys_rst(sys_rst),
        .host_addr(win_host_addr),
        .host_we(win_host_we),
        .host_wdata(win_host_wdata),
        .host_rdata(win_host_rdata),
        .win(win_bus)
    );

    dall_state_t state_ff;
    dall_state_t nxt_state;
    logic [15:0] remain_ff;
    logic [15:0] nxt_remain;
    logic [WIN_AW-1:0] idx_ff;
    logic [WIN_AW-1:0] nxt_idx;
    logic req_open_ff;
    logic nxt_req_open;
    logic hs_done_ff;
    logic nxt_hs_done;
    logic [31:0] pack_ff;
    logic [1:0] pack_cnt_ff;
    logic pack_full_ff;
    logic [47:0] ser_ff;
    logic [2:0] ser_cnt_ff;
    logic [31:0] req_word_ff;
    logic req_valid_ff;
    logic req_last_ff;
    logic [31:0] mbx_tx_word_ff;
    logic mbx_tx_valid_ff;

    wire mode_byte = link_mode == MODE_BYTE;
    wire mode_mbox = link_mode == MODE_MBOX;
    wire mode_win = link_mode == MODE_WINDOW;
    wire st_in = state_ff == ST_IDLE || state_ff == ST_REQ;
    wire st_rsp = state_ff == ST_RSP_HDR || state_ff == ST_RSP_DATA;
    wire req_free = !req_valid_ff || req_ready;
    wire want_in = st_in ? req_free : state_ff == ST_RSP_ACK;
    wire in_valid = mode_byte ? pack_full_ff : mode_mbox ? mbx_rx_valid : req_open_ff && st_in;
    wire [31:0] in_word = mode_byte ? pack_ff : mode_mbox ? mbx_rx_word : win_bus.rdata;
    wire in_take = in_valid && want_in;
    wire [15:0] in_len = in_word[31:16];
    wire [15:0] rsp_len = rsp_word[31:16];
    wire [15:0] rem_dec = remain_ff - 16'h0001;
    wire ack_ok = in_word[15:0] == ACK_MARKER;
    wire req_is_last = state_ff == ST_IDLE ? in_len == RST_COUNT : rem_dec == RST_COUNT;
    wire out_ready = mode_byte ? ser_cnt_ff == 3'h0 : mode_mbox ? !mbx_tx_valid_ff : 1'b1;
    wire rsp_step = st_rsp && rsp_valid && out_ready;
    wire tok_step = state_ff == ST_REQ_ACK && out_ready;
    wire out_fire = rsp_step || tok_step;
    wire [31:0] ack_word = {remain_ff, ACK_MARKER};
    wire [31:0] out_word = tok_step ? ack_word : rsp_word;
    wire disc_hit = byte_rx_valid && byte_rx_ready && state_ff == ST_IDLE && pack_cnt_ff == 2'h0
        && byte_rx_data == IDENT_REQUEST_BYTE;
    wire byte_take = byte_rx_valid && byte_rx_ready && !disc_hit;
    wire ser_shift = byte_tx_valid && byte_tx_ready;
    wire win_poll = mode_win && state_ff == ST_IDLE && !req_open_ff;
    wire win_go = win_poll && win_bus.status0 == WINDOW_HOST_DONE_VALUE;
    wire win_hs = win_poll && !win_go && win_bus.hs_seen && !hs_done_ff;
    wire [WIN_AW-1:0] msg_addr = WIN_MSG_BASE + idx_ff;
    dall_state_t fin_state;
    assign fin_state = mode_win ? ST_WIN_DONE : ST_IDLE;

    // Half-duplex: new bytes wait while an answer is still going out.
    assign byte_rx_ready = mode_byte && !pack_full_ff && ser_cnt_ff == 3'h0;
    assign byte_tx_valid = ser_cnt_ff != 3'h0;
    assign byte_tx_data = ser_ff[7:0];
    assign mbx_rx_ready = mode_mbox && want_in;
    assign mbx_tx_word = mbx_tx_word_ff;
    assign mbx_tx_valid = mbx_tx_valid_ff;
    assign req_word = req_word_ff;
    assign req_valid = req_valid_ff;
    assign req_last = req_last_ff;
    assign rsp_ready = st_rsp && out_ready;

    assign win_bus.we = mode_win && (state_ff == ST_WIN_HS || state_ff == ST_WIN_DONE || rsp_step);
    assign win_bus.addr = state_ff == ST_WIN_HS ? idx_ff : state_ff == ST_WIN_DONE ? WIN_STATUS0 : msg_addr;
    assign win_bus.wdata = state_ff == ST_WIN_HS ? (idx_ff[0] ? WINDOW_HANDSHAKE_SECOND : WINDOW_HANDSHAKE_FIRST)
        : state_ff == ST_WIN_DONE ? WINDOW_TARGET_DONE_VALUE : rsp_word;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_remain = remain_ff;
        nxt_idx = idx_ff;
        nxt_req_open = req_open_ff;
        nxt_hs_done = hs_done_ff;
        unique case (state_ff)
            ST_IDLE:
            begin
                if (win_go)
                begin
                    nxt_req_open = 1'b1;
                    nxt_hs_done = 1'b0;
                    nxt_idx = '0;
                end
                else if (win_hs)
                begin
                    nxt_state = ST_WIN_HS;
                    nxt_idx = '0;
                end
                else if (in_take)
                begin
                    // The header never earns a token; its length sets the count.
                    nxt_remain = in_len;
                    nxt_idx = idx_ff + 6'h01;
                    if (in_len == RST_COUNT)
                    begin
                        nxt_state = ST_RSP_HDR;
                        nxt_idx = '0;
                    end
                    else
                        nxt_state = ST_REQ;
                end
            end
            ST_REQ:
            begin
                if (in_take)
                begin
                    nxt_remain = rem_dec;
                    nxt_idx = idx_ff + 6'h01;
                    if (mode_mbox)
                        nxt_state = ST_REQ_ACK;
                    else if (rem_dec == RST_COUNT)
                    begin
                        nxt_state = ST_RSP_HDR;
                        nxt_idx = '0;
                    end
                end
            end
            ST_REQ_ACK:
            begin
                if (tok_step)
                begin
                    if (remain_ff == RST_COUNT)
                    begin
                        nxt_state = ST_RSP_HDR;
                        nxt_idx = '0;
                    end
                    else
                        nxt_state = ST_REQ;
                end
            end
            ST_RSP_HDR:
            begin
                if (rsp_step)
                begin
                    nxt_remain = rsp_len;
                    nxt_idx = idx_ff + 6'h01;
                    nxt_state = rsp_len == RST_COUNT ? fin_state : ST_RSP_DATA;
                end
            end
            ST_RSP_DATA:
            begin
                if (rsp_step)
                begin
                    nxt_remain = rem_dec;
                    nxt_idx = idx_ff + 6'h01;
                    if (mode_mbox)
                        nxt_state = ST_RSP_ACK;
                    else if (rem_dec == RST_COUNT)
                        nxt_state = fin_state;
                end
            end
            ST_RSP_ACK:
            begin
                // Words without the marker are not tokens and are dropped.
                if (in_take && ack_ok)
                    nxt_state = remain_ff == RST_COUNT ? ST_IDLE : ST_RSP_DATA;
            end
            ST_WIN_HS:
            begin
                nxt_idx = idx_ff + 6'h01;
                if (idx_ff == WIN_HS_LAST)
                begin
                    nxt_state = ST_IDLE;
                    nxt_hs_done = 1'b1;
                end
            end
            ST_WIN_DONE:
            begin
                nxt_state = ST_IDLE;
                nxt_req_open = 1'b0;
            end
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_ff <= ST_IDLE;
            remain_ff <= RST_COUNT;
            idx_ff <= '0;
            req_open_ff <= 1'b0;
            hs_done_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            remain_ff <= nxt_remain;
            idx_ff <= nxt_idx;
            req_open_ff <= nxt_req_open;
            hs_done_ff <= nxt_hs_done;
        end
    end

    // Incoming bytes fill a word from its low byte upward.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pack_ff <= RST_WORD;
            pack_cnt_ff <= 2'h0;
            pack_full_ff <= 1'b0;
        end
        else if (byte_take)
        begin
            pack_ff[{pack_cnt_ff, 3'h0} +: 8] <= byte_rx_data;
            pack_cnt_ff <= pack_cnt_ff + 2'h1;
            pack_full_ff <= pack_cnt_ff == 2'h3;
        end
        else if (in_take && mode_byte)
            pack_full_ff <= 1'b0;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ser_ff <= '0;
            ser_cnt_ff <= 3'h0;
        end
        else if (disc_hit)
        begin
            ser_ff <= DISC_SEQ;
            ser_cnt_ff <= DISC_LEN;
        end
        else if (out_fire && mode_byte)
        begin
            ser_ff <= {16'h0000, out_word};
            ser_cnt_ff <= WORD_BYTES;
        end
        else if (ser_shift)
        begin
            ser_ff <= ser_ff >> 8;
            ser_cnt_ff <= ser_cnt_ff - 3'h1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mbx_tx_word_ff <= RST_WORD;
            mbx_tx_valid_ff <= 1'b0;
        end
        else if (out_fire && mode_mbox)
        begin
            mbx_tx_word_ff <= out_word;
            mbx_tx_valid_ff <= 1'b1;
        end
        else if (mbx_tx_ready)
            mbx_tx_valid_ff <= 1'b0;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            req_word_ff <= RST_WORD;
            req_valid_ff <= 1'b0;
            req_last_ff <= 1'b0;
        end
        else if (in_take && st_in)
        begin
            req_word_ff <= in_word;
            req_valid_ff <= 1'b1;
            req_last_ff <= req_is_last;
        end
        else if (req_ready)
            req_valid_ff <= 1'b0;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_hs_walk;
        win_bus.we && win_bus.addr == 6'h00 && win_bus.wdata == WINDOW_HANDSHAKE_FIRST
        ##1 win_bus.we && win_bus.addr == 6'h01 && win_bus.wdata == WINDOW_HANDSHAKE_SECOND
        ##1 win_bus.we && win_bus.addr == 6'h02 && win_bus.wdata == WINDOW_HANDSHAKE_FIRST
        ##1 win_bus.we && win_bus.addr == 6'h03 && win_bus.wdata == WINDOW_HANDSHAKE_SECOND;
    endsequence

    chk_ident_bytes: assert property (
        disc_hit |=> ser_ff[39:8] == PROTOCOL_ID && ser_cnt_ff == DISC_LEN)
        else $error("identifier bytes wrong");
    chk_disc_answer: assert property (
        disc_hit |=> byte_tx_valid && byte_tx_data == IDENT_ANSWER_BYTE && ser_ff[47:40] == 8'had)
        else $error("discovery answer wrong");
    chk_lsb_first: assert property (
        (ser_shift && ser_cnt_ff > 3'h1) |=> byte_tx_data == $past(ser_ff[15:8]))
        else $error("byte order wrong");
    chk_mbx_hold: assert property (
        (mbx_tx_valid && !mbx_tx_ready) |=> mbx_tx_valid && $stable(mbx_tx_word))
        else $error("mailbox word dropped");
    chk_ack_each: assert property (
        (mode_mbox && state_ff == ST_REQ && in_take) |=> state_ff == ST_REQ_ACK ##[0:300] tok_step)
        else $error("data word without token");
    chk_rsp_stall: assert property (
        state_ff == ST_RSP_ACK |-> !rsp_ready)
        else $error("reply sent before token");
    chk_hdr_noack: assert property (
        (mode_mbox && state_ff == ST_IDLE && in_take) |=> state_ff != ST_REQ_ACK)
        else $error("header got a token");
    chk_ack_count: assert property (
        tok_step |=> mbx_tx_valid && mbx_tx_word[31:16] == $past(remain_ff))
        else $error("token count wrong");
    chk_ack_marker: assert property (
        tok_step |=> mbx_tx_word[15:0] == ACK_MARKER)
        else $error("token marker wrong");
    chk_hs_pattern: assert property (
        win_hs |=> s_hs_walk)
        else $error("handshake pattern wrong");
    chk_read_gate: assert property (
        $rose(req_open_ff) |-> $past(win_bus.status0) == WINDOW_HOST_DONE_VALUE)
        else $error("request read without host done");
    chk_done_write: assert property (
        (mode_win && state_ff == ST_RSP_DATA && rsp_step && rem_dec == RST_COUNT)
        |=> win_bus.we && win_bus.addr == WIN_STATUS0 && win_bus.wdata == WINDOW_TARGET_DONE_VALUE)
        else $error("target done not written");
    chk_poll_wait: assert property (
        (win_poll && win_bus.status0 != WINDOW_HOST_DONE_VALUE) |=> !req_open_ff)
        else $error("window opened on wrong status");
endmodule : dall_link
`default_nettype wire

// ---- core/dall_window.sv ----
`timescale 1ns/1ps
`default_nettype none
module dall_window (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [dall_pkg::WIN_AW-1:0] host_addr,
    input wire logic host_we,
    input wire logic [31:0] host_wdata,
    output logic [31:0] host_rdata,
    dall_win_if.mem win
);
    import dall_pkg::*;
    logic [31:0] mem_ff [WIN_WORDS];
    logic [31:0] host_rdata_ff;

    // Every word resets so a stale pattern can never fake a handshake.
    // On a same-cycle clash the target write wins.
    for (genvar i = 0; i < WIN_WORDS; i++)
    begin : g_word
        always_ff @(posedge clk or posedge sys_rst)
        begin
            if (sys_rst)
                mem_ff[i] <= RST_WORD;
            else if (win.we && win.addr == WIN_AW'(i))
                mem_ff[i] <= win.wdata;
            else if (host_we && host_addr == WIN_AW'(i))
                mem_ff[i] <= host_wdata;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            host_rdata_ff <= RST_WORD;
        else
            host_rdata_ff <= mem_ff[host_addr];
    end

    assign host_rdata = host_rdata_ff;
    assign win.rdata = mem_ff[win.addr];
    assign win.status0 = mem_ff[0];
    assign win.hs_seen = mem_ff[0] == WINDOW_HANDSHAKE_FIRST && mem_ff[1] == WINDOW_HANDSHAKE_SECOND
        && mem_ff[2] == WINDOW_HANDSHAKE_FIRST && mem_ff[3] == WINDOW_HANDSHAKE_SECOND;
endmodule : dall_window
`default_nettype wire

// ---- inc/dall_pkg.sv ----
package dall_pkg;
    localparam logic [7:0] IDENT_REQUEST_BYTE = 8'ha0;
    localparam logic [7:0] IDENT_ANSWER_BYTE = 8'ha1;
    localparam logic [31:0] PROTOCOL_ID = 32'h43414441;
    localparam logic [47:0] DISC_SEQ = {8'had, PROTOCOL_ID, IDENT_ANSWER_BYTE};
    localparam logic [2:0] DISC_LEN = 3'h6;
    localparam logic [2:0] WORD_BYTES = 3'h4;
    localparam logic [15:0] ACK_MARKER = 16'ha5a5;
    localparam logic [31:0] WINDOW_HOST_DONE_VALUE = 32'h12121212;
    localparam logic [31:0] WINDOW_TARGET_DONE_VALUE = 32'hefefefef;
    localparam logic [31:0] WINDOW_HANDSHAKE_FIRST = 32'hff00ff00;
    localparam logic [31:0] WINDOW_HANDSHAKE_SECOND = 32'h00ff00ff;
    localparam int WIN_AW = 6;
    localparam int WIN_WORDS = 64;
    localparam logic [5:0] WIN_STATUS0 = 6'h00;
    localparam logic [5:0] WIN_MSG_BASE = 6'h04;
    localparam logic [5:0] WIN_HS_LAST = 6'h03;
    localparam logic [31:0] RST_WORD = 32'h00000000;
    localparam logic [15:0] RST_COUNT = 16'h0000;

    typedef enum logic [1:0] {
        MODE_BYTE = 2'b00,
        MODE_MBOX = 2'b01,
        MODE_WINDOW = 2'b10
    } dall_mode_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_REQ = 4'b0001,
        ST_REQ_ACK = 4'b0010,
        ST_RSP_HDR = 4'b0011,
        ST_RSP_DATA = 4'b0100,
        ST_RSP_ACK = 4'b0101,
        ST_WIN_HS = 4'b0110,
        ST_WIN_DONE = 4'b0111
    } dall_state_t;
endpackage : dall_pkg

// ---- inc/dall_win_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface dall_win_if;
    import dall_pkg::*;
    logic we;
    logic [WIN_AW-1:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] status0;
    logic hs_seen;
    modport core (output we, output addr, output wdata, input rdata, input status0, input hs_seen);
    modport mem (input we, input addr, input wdata, output rdata, output status0, output hs_seen);
endinterface : dall_win_if
`default_nettype wire

// ---- testbench/dall_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Behavioural debug host on the byte channel: opens discovery and collects the answer bytes.
module dall_host_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic go,
    input wire logic slow,
    output logic [7:0] byte_rx_data,
    output logic byte_rx_valid,
    input wire logic byte_rx_ready,
    input wire logic [7:0] byte_tx_data,
    input wire logic byte_tx_valid,
    output logic byte_tx_ready,
    output logic [47:0] ans,
    output logic [2:0] ans_cnt,
    output logic id_ok
);
    logic go_ff;

    // The host only carries on with this command protocol when the identifier matches.
    assign id_ok = (ans[39:8] === 32'h43414441);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            go_ff <= 1'b0;
            byte_rx_data <= 8'h00;
            byte_rx_valid <= 1'b0;
            byte_tx_ready <= 1'b0;
            ans <= 48'h000000000000;
            ans_cnt <= 3'h0;
        end
        else
        begin
            go_ff <= go;
            if (go && !go_ff)
            begin
                byte_rx_data <= 8'ha0;
                byte_rx_valid <= 1'b1;
                ans_cnt <= 3'h0;
            end
            else if (byte_rx_valid && byte_rx_ready)
            begin
                // A released line shows the inverse so a stale byte can never look valid.
                byte_rx_valid <= 1'b0;
                byte_rx_data <= ~byte_rx_data;
            end
            if (byte_tx_valid && byte_tx_ready)
            begin
                ans <= {byte_tx_data, ans[47:8]};
                ans_cnt <= ans_cnt + 3'h1;
            end
            byte_tx_ready <= slow ? ~byte_tx_ready : 1'b1;
        end
    end
endmodule : dall_host_model
`default_nettype wire

// ---- testbench/debug_auth_link_layer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module debug_auth_link_layer_tb;
    import dall_pkg::*;
    logic clk, sys_rst, go, slow;
    dall_mode_t link_mode;
    logic [7:0] byte_rx_data, byte_tx_data;
    logic byte_rx_valid, byte_rx_ready, byte_tx_valid, byte_tx_ready;
    logic [31:0] mbx_rx_word, mbx_tx_word, win_host_wdata, win_host_rdata, req_word, rsp_word;
    logic mbx_rx_valid, mbx_rx_ready, mbx_tx_valid, mbx_tx_ready;
    logic [WIN_AW-1:0] win_host_addr;
    logic win_host_we, req_valid, req_last, req_ready, rsp_valid, rsp_ready, id_ok;
    logic [47:0] ans;
    logic [2:0] ans_cnt;
    int n_mismatch = 0;
    int check_count = 0;

    dall_link dut (.clk(clk), .sys_rst(sys_rst), .link_mode(link_mode), .byte_rx_data(byte_rx_data),
        .byte_rx_valid(byte_rx_valid), .byte_rx_ready(byte_rx_ready), .byte_tx_data(byte_tx_data),
        .byte_tx_valid(byte_tx_valid), .byte_tx_ready(byte_tx_ready), .mbx_rx_word(mbx_rx_word),
        .mbx_rx_valid(mbx_rx_valid), .mbx_rx_ready(mbx_rx_ready), .mbx_tx_word(mbx_tx_word),
        .mbx_tx_valid(mbx_tx_valid), .mbx_tx_ready(mbx_tx_ready), .win_host_addr(win_host_addr),
        .win_host_we(win_host_we), .win_host_wdata(win_host_wdata), .win_host_rdata(win_host_rdata),
        .req_word(req_word), .req_valid(req_valid), .req_last(req_last), .req_ready(req_ready),
        .rsp_word(rsp_word), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready));

    dall_host_model u_host (.clk(clk), .sys_rst(sys_rst), .go(go), .slow(slow), .byte_rx_data(byte_rx_data),
        .byte_rx_valid(byte_rx_valid), .byte_rx_ready(byte_rx_ready), .byte_tx_data(byte_tx_data),
        .byte_tx_valid(byte_tx_valid), .byte_tx_ready(byte_tx_ready), .ans(ans), .ans_cnt(ans_cnt),
        .id_ok(id_ok));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic close_out();
        if (n_mismatch == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // Requests are held until ready is seen high ahead of the taking edge.
    task automatic send_mbx(input logic [31:0] w);
        int n;
        mbx_rx_word = w;
        mbx_rx_valid = 1'b1;
        for (n = 0; n < 100 && mbx_rx_ready !== 1'b1; n++) tick(1);
        tick(1);
        mbx_rx_valid = 1'b0;
        chk(n < 100, 1'b1);
    endtask : send_mbx

    task automatic send_rsp(input logic [31:0] w);
        int n;
        rsp_word = w;
        rsp_valid = 1'b1;
        for (n = 0; n < 100 && rsp_ready !== 1'b1; n++) tick(1);
        tick(1);
        rsp_valid = 1'b0;
        chk(n < 100, 1'b1);
    endtask : send_rsp

    task automatic recv_mbx(input logic [31:0] exp);
        int n;
        for (n = 0; n < 100 && mbx_tx_valid !== 1'b1; n++) tick(1);
        chk(mbx_tx_word, exp);
        mbx_tx_ready = 1'b1;
        tick(1);
        mbx_tx_ready = 1'b0;
    endtask : recv_mbx

    task automatic take_req(input logic [31:0] exp, input logic last);
        int n;
        for (n = 0; n < 100 && req_valid !== 1'b1; n++) tick(1);
        chk(req_word, exp);
        chk(req_last, last);
        req_ready = 1'b1;
        tick(1);
        req_ready = 1'b0;
    endtask : take_req

    // A write that is followed by another keeps the strobe up instead of lowering and raising it at once.
    task automatic win_wr(input logic [WIN_AW-1:0] a, input logic [31:0] d, input logic hold = 1'b0);
        win_host_addr = a;
        win_host_wdata = d;
        win_host_we = 1'b1;
        tick(1);
        win_host_we = hold;
    endtask : win_wr

    task automatic win_rd(input logic [WIN_AW-1:0] a, output logic [31:0] d);
        win_host_addr = a;
        tick(1);
        d = win_host_rdata;
    endtask : win_rd

    task automatic t_disc();
        int n;
        link_mode = MODE_BYTE;
        for (int s = 1; s >= 0; s--)
        begin
            slow = s[0];
            go = 1'b1;
            // The start edge must clear the count left from the previous round before it is polled.
            tick(2);
            for (n = 0; n < 100 && ans_cnt !== 3'h6; n++) tick(1);
            tick(4);
            chk(ans, 48'had43414441a1);
            chk(id_ok, 1'b1);
            chk(byte_tx_valid, 1'b0);
            go = 1'b0;
            tick(2);
        end
    endtask : t_disc

    task automatic t_mbox();
        link_mode = MODE_MBOX;
        tick(1);
        send_mbx(32'h00020007);
        take_req(32'h00020007, 1'b0);
        tick(3);
        chk(mbx_tx_valid, 1'b0);
        send_mbx(32'h11110001);
        take_req(32'h11110001, 1'b0);
        recv_mbx(32'h0001a5a5);
        send_mbx(32'h22220002);
        take_req(32'h22220002, 1'b1);
        recv_mbx(32'h0000a5a5);
        send_rsp(32'h00020000);
        recv_mbx(32'h00020000);
        send_rsp(32'h3333000a);
        recv_mbx(32'h3333000a);
        rsp_word = 32'h4444000b;
        rsp_valid = 1'b1;
        tick(6);
        chk(mbx_tx_valid, 1'b0);
        send_mbx(32'h00015a5a);
        tick(2);
        chk(mbx_tx_valid, 1'b0);
        send_mbx(32'h0001a5a5);
        send_rsp(32'h4444000b);
        recv_mbx(32'h4444000b);
        send_mbx(32'h0000a5a5);
    endtask : t_mbox

    task automatic t_window();
        logic [31:0] d;
        int n;
        link_mode = MODE_WINDOW;
        tick(1);
        win_wr(6'h00, 32'h12121213);
        tick(10);
        chk(req_valid, 1'b0);
        for (int i = 0; i < 4; i++) win_wr(i[5:0], i[0] ? 32'h00ff00ff : 32'hff00ff00, 1'b1);
        // Spoiling word 3 before the target reaches it proves that the read back is the target's write.
        win_wr(6'h03, 32'h00000000);
        tick(7);
        for (int i = 0; i < 4; i++)
        begin
            win_rd(i[5:0], d);
            chk(d, i[0] ? 32'h00ff00ff : 32'hff00ff00);
        end
        win_wr(6'h04, 32'h00010000, 1'b1);
        win_wr(6'h05, 32'hcafe0005);
        tick(5);
        chk(req_valid, 1'b0);
        win_wr(6'h00, 32'h12121212);
        take_req(32'h00010000, 1'b0);
        tick(1);
        take_req(32'hcafe0005, 1'b1);
        send_rsp(32'h00010001);
        tick(1);
        send_rsp(32'h5eed0001);
        for (n = 0; n < 50 && d !== 32'hefefefef; n++) win_rd(6'h00, d);
        chk(d, 32'hefefefef);
        win_rd(6'h04, d);
        chk(d, 32'h00010001);
        win_rd(6'h05, d);
        chk(d, 32'h5eed0001);
    endtask : t_window

    initial
    begin
        #(30000 * 4);
        n_mismatch++;
        close_out();
    end

    initial
    begin
        {go, slow} = 2'h0;
        link_mode = MODE_BYTE;
        {mbx_rx_word, mbx_rx_valid, mbx_tx_ready, req_ready, rsp_word, rsp_valid} = 68'h0;
        {win_host_addr, win_host_we, win_host_wdata} = 39'h0;
        sys_rst = 1'b1;
        tick(3);
        sys_rst = 1'b0;
        chk({byte_tx_valid, mbx_tx_valid, req_valid}, 3'h0);
        t_disc();
        t_mbox();
        t_window();
        close_out();
    end
endmodule : debug_auth_link_layer_tb
`default_nettype wire
